// >>> design/ddc_pkg.sv
/*
 * Shared constants and types for the dual-port converter clock and interleave control.
 * Assumes a single 250 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package ddc_pkg;

	// ==========================================================
	// Widths
	localparam int SAMPLE_W   = 10;              // Converter sample width
	localparam int FIFO_DEPTH = 8;               // Sample pair buffer depth
	localparam int WB_ADR_W   = 8;               // Byte address width

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFS   = 8'h00;   // Clock mode and select bits
	localparam logic [7:0] STATUS_OFS = 8'h04;   // Lock, sync clock, fifo state

	// ==========================================================
	// Field positions
	localparam int CTRL_LOOP_EN_BIT   = 0;       // Internal multiplier enable
	localparam int CTRL_SEL_LOW_BIT   = 1;       // ratio_select_low
	localparam int CTRL_SEL_HIGH_BIT  = 2;       // ratio_select_high
	localparam int STAT_LOCK_BIT      = 0;       // Loop locked
	localparam int STAT_IND_BIT       = 1;       // Lock indicator pin level
	localparam int STAT_UNDERRUN_BIT  = 2;       // Sticky underrun, write 1 to clear
	localparam int STAT_FIFO_LVL_LSB  = 4;       // Fifo fill level, 4 bits

	// ==========================================================
	// Reset values
	localparam logic [2:0] CTRL_RESET = 3'h0;    // External clock, interleaved

	// ==========================================================
	// Select encoding with the multiplier off
	localparam logic [1:0] SEL_INTERLEAVED = 2'h0; // Any other value: port 1 only

	// ==========================================================
	// Timing
	localparam int CLK_MHZ      = 250;           // System clock rate
	localparam int LOCK_TIME_NS = 1000;          // Loop settling time
	localparam int LOCK_CYCLES  = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int LOCK_CNT_W   = 9;             // Holds LOCK_CYCLES

	// ==========================================================
	// Types
	typedef struct packed {
		logic [SAMPLE_W-1:0] port2;                // Second input port sample
		logic [SAMPLE_W-1:0] port1;                // First input port sample
	} ddc_pair_t;

	typedef struct packed {
		logic [1:0] sel;                           // {ratio_select_high, ratio_select_low}
		logic       loop_en;                       // Internal multiplier enable
	} ddc_ctrl_t;

	typedef enum logic [0:0] {
		PH_FIRST  = 1'b0,                          // First half of a port period
		PH_SECOND = 1'b1                           // Second half of a port period
	} ddc_phase_t;

endpackage

// >>> design/ddc_top.sv
/*
 * Clock mode and port interleave control of a dual-port converter, plus its pair fifo.
 * Assumes the data source is logic on MCLK_IN and the core updates once per MCLK_IN cycle.
 */
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
// Overview of operation
// - Interleave both ports, core at double port rate
// - Multiplier on: device makes its own update timing
// - Multiplier on: indicator shows loop lock
// - Multiplier on: select bits set divider ratio; here a change of them only restarts lock settling
// - Multiplier off: full-rate clock divided by two
// - Multiplier off: indicator carries port-rate clock
// - Multiplier off: select bits choose interleave mode
`timescale 1ns/1ns

// ==========================================================
// Synchronous fifo with valid and ready on both sides
module ddc_fifo #(
	parameter int W = 20,                          // Word width
	parameter int D = 8                            // Depth in words
) (
	input  wire logic           clk_in,            // System clock
	input  wire logic           rst_in,            // Asynchronous reset, high
	input  wire logic           in_valid_in,       // Write request
	output logic                in_ready_out,      // Not full
	input  wire logic [W-1:0]   in_data_in,        // Write data
	output logic                out_valid_out,     // Not empty
	input  wire logic           out_ready_in,      // Read request
	output logic [W-1:0]        out_data_out,      // Head word
	output logic [$clog2(D):0]  level_out          // Words held
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];                       // Storage array
	logic [AW-1:0] wr_q, wr_d;                     // Write pointer
	logic [AW-1:0] rd_q, rd_d;                     // Read pointer
	logic [AW:0]   cnt_q, cnt_d;                   // Fill count
	logic          push, pop;                      // Accepted transfers

	assign in_ready_out  = (cnt_q != AW'(0) + (AW+1)'(D)) ? 1'b1 : 1'b0;
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out  = mem_q[rd_q];
	assign level_out     = cnt_q;
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// Pointer and count next values
	always_comb begin
		wr_d  = push ? wr_q + AW'(1) : wr_q;
		rd_d  = pop ? rd_q + AW'(1) : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Pointer and count registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage writes, no reset needed
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end
endmodule

// ==========================================================
// Top: register slave, clock mode control and port interleaver
module ddc_top
	import ddc_pkg::*;
(
	input  wire logic                 MCLK_IN,                 // 250 MHz update clock
	input  wire logic                 RST_IN,                  // Asynchronous reset, high
	input  wire logic                 WB_CYC_IN,               // Wishbone cycle
	input  wire logic                 WB_STB_IN,               // Wishbone strobe
	input  wire logic                 WB_WE_IN,                // Wishbone write
	input  wire logic [WB_ADR_W-1:0]  WB_ADR_IN,               // Wishbone byte address
	input  wire logic [3:0]           WB_SEL_IN,               // Wishbone byte enables
	input  wire logic [31:0]          WB_DAT_IN,               // Wishbone write data
	output logic      [31:0]          WB_DAT_OUT,              // Wishbone read data
	output logic                      WB_ACK_OUT,              // Wishbone acknowledge
	input  wire logic                 SRC_VALID_IN,            // Source pair valid
	input  wire ddc_pair_t            SRC_DATA_IN,             // Source port 1 and 2 samples
	output logic                      SRC_READY_OUT,           // Fifo can take a pair
	output logic      [SAMPLE_W-1:0]  CORE_DATA_OUT,           // Sample to converter core
	output logic                      CORE_UPDATE_OUT,         // Core latches CORE_DATA_OUT
	output logic                      LOOP_LOCK_INDICATOR_OUT  // Lock or 1x sync clock
);
	// ==========================================================
	// Declarations
	ddc_ctrl_t            ctrl_q, ctrl_d;            // Control register
	logic                 ack_q, ack_d;              // Bus acknowledge
	logic [31:0]          rdat_q, rdat_d;            // Bus read data
	logic [LOCK_CNT_W-1:0] lock_cnt_q, lock_cnt_d;   // Settling counter
	logic                 lock_q, lock_d;            // Loop locked
	ddc_phase_t           phase_q, phase_d;          // Half of port period
	ddc_pair_t            pair_q, pair_d;            // Pair being played
	logic [SAMPLE_W-1:0]  core_q, core_d;            // Core sample register
	logic                 upd_q, upd_d;              // Core update strobe
	logic                 sync_q, sync_d;            // Port-rate sync clock
	logic                 ind_q, ind_d;              // Indicator pin register
	logic                 under_q, under_d;          // Sticky underrun
	logic                 bus_req;                   // New bus request
	logic                 wr_ctrl, wr_stat;          // Register write strobes
	logic                 running;                   // Core may update
	logic                 interleave;                // Both ports played
	logic                 pop;                       // Take a pair from fifo
	logic                 f_valid;                   // Fifo holds a pair
	ddc_pair_t            f_data;                    // Fifo head pair
	logic [3:0]           f_level;                   // Fifo fill level

	// Decode a byte address to a mapped register
	function automatic logic hit(input logic [WB_ADR_W-1:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// ==========================================================
	// Pair fifo in the data path
	ddc_fifo #(
		.W (2 * SAMPLE_W),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (MCLK_IN),
		.rst_in        (RST_IN),
		.in_valid_in   (SRC_VALID_IN),
		.in_ready_out  (SRC_READY_OUT),
		.in_data_in    (SRC_DATA_IN),
		.out_valid_out (f_valid),
		.out_ready_in  (pop),
		.out_data_out  (f_data),
		.level_out     (f_level)
	);

	// ==========================================================
	// Wishbone slave: one wait state, unmapped reads return zero
	assign bus_req = WB_CYC_IN && WB_STB_IN && !ack_q;
	assign wr_ctrl = bus_req && WB_WE_IN && WB_SEL_IN[0] && hit(WB_ADR_IN, CTRL_OFS);
	assign wr_stat = bus_req && WB_WE_IN && WB_SEL_IN[0] && hit(WB_ADR_IN, STATUS_OFS);

	// Bus next values
	always_comb begin
		ack_d  = bus_req;
		rdat_d = rdat_q;
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d.loop_en = WB_DAT_IN[CTRL_LOOP_EN_BIT];
			ctrl_d.sel     = {WB_DAT_IN[CTRL_SEL_HIGH_BIT], WB_DAT_IN[CTRL_SEL_LOW_BIT]};
		end
		if (bus_req && !WB_WE_IN) begin
			rdat_d = '0;
			if (hit(WB_ADR_IN, CTRL_OFS)) begin
				rdat_d[CTRL_SEL_HIGH_BIT:CTRL_LOOP_EN_BIT] = ctrl_q;
			end else if (hit(WB_ADR_IN, STATUS_OFS)) begin
				rdat_d[STAT_LOCK_BIT]     = lock_q;
				rdat_d[STAT_IND_BIT]      = ind_q;
				rdat_d[STAT_UNDERRUN_BIT] = under_q;
				rdat_d[STAT_FIFO_LVL_LSB +: 4] = f_level;
			end
		end
	end

	// Bus registers
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
			ctrl_q <= CTRL_RESET;
		end else begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign WB_ACK_OUT = ack_q;
	assign WB_DAT_OUT = rdat_q;

	// ==========================================================
	// Loop lock model: any change of mode or ratio restarts settling
	always_comb begin
		lock_cnt_d = lock_cnt_q;
		lock_d     = lock_q;
		if (!ctrl_q.loop_en || (wr_ctrl && ctrl_d != ctrl_q)) begin
			lock_cnt_d = '0;
			lock_d     = 1'b0;
		end else if (!lock_q) begin
			if (lock_cnt_q == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
				lock_d = 1'b1;
			end else begin
				lock_cnt_d = lock_cnt_q + LOCK_CNT_W'(1);
			end
		end
	end

	// Lock registers
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			lock_cnt_q <= '0;
			lock_q     <= 1'b0;
		end else begin
			lock_cnt_q <= lock_cnt_d;
			lock_q     <= lock_d;
		end
	end

	// ==========================================================
	// Interleaver: update every cycle, take a pair every second cycle
	assign running    = ctrl_q.loop_en ? lock_q : 1'b1;
	assign interleave = ctrl_q.loop_en || (ctrl_q.sel == SEL_INTERLEAVED);
	assign pop        = running && (phase_q == PH_FIRST) && f_valid;

	// Datapath next values
	always_comb begin
		phase_d = phase_q;
		pair_d  = pair_q;
		core_d  = core_q;
		upd_d   = 1'b0;
		sync_d  = sync_q;
		under_d = under_q;
		if (wr_stat && WB_DAT_IN[STAT_UNDERRUN_BIT]) begin
			under_d = 1'b0;                          // Clear loses to a new underrun
		end
		if (!running) begin
			phase_d = PH_FIRST;
		end else if (phase_q == PH_FIRST) begin
			if (f_valid) begin
				pair_d = f_data;
				core_d = f_data.port1;
			end else begin
				core_d  = pair_q.port1;                // Underrun repeats last pair
				under_d = 1'b1;
			end
			upd_d   = 1'b1;
			phase_d = PH_SECOND;
			sync_d  = 1'b1;
		end else begin
			core_d  = interleave ? pair_q.port2 : pair_q.port1;
			upd_d   = 1'b1;
			phase_d = PH_FIRST;
			sync_d  = 1'b0;
		end
		ind_d = ctrl_q.loop_en ? lock_q : sync_d;
	end

	// Datapath registers
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			phase_q <= PH_FIRST;
			pair_q  <= '0;
			core_q  <= '0;
			upd_q   <= 1'b0;
			sync_q  <= 1'b0;
			ind_q   <= 1'b0;
			under_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			pair_q  <= pair_d;
			core_q  <= core_d;
			upd_q   <= upd_d;
			sync_q  <= sync_d;
			ind_q   <= ind_d;
			under_q <= under_d;
		end
	end

	assign CORE_DATA_OUT           = core_q;
	assign CORE_UPDATE_OUT         = upd_q;
	assign LOOP_LOCK_INDICATOR_OUT = ind_q;

	// ==========================================================
	// Checks
	a_interleave_order: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		pop |=> CORE_DATA_OUT == $past(f_data.port1))
		else $error("first port sample not played first");

	a_second_port: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(running && phase_q == PH_SECOND && interleave) |=> CORE_DATA_OUT == $past(pair_q.port2))
		else $error("second port sample not played");

	a_double_rate: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(running && phase_q == PH_FIRST) |=> phase_q == PH_SECOND ##1 phase_q == PH_FIRST)
		else $error("port period is not two updates");

	a_update_rate: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(running && $past(running) && !$past(RST_IN)) |-> CORE_UPDATE_OUT)
		else $error("core update missed while running");

	a_lock_time: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		$rose(lock_q) |-> lock_cnt_q == LOCK_CNT_W'(LOCK_CYCLES - 1) && ctrl_q.loop_en)
		else $error("lock raised at wrong time");

	a_ratio_relock: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(wr_ctrl && ctrl_d != ctrl_q) |=> !lock_q && lock_cnt_q == '0)
		else $error("ratio change did not restart lock");

	a_sync_clock: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(!ctrl_q.loop_en && $past(!ctrl_q.loop_en) && $past(!ctrl_q.loop_en, 2) && !$past(RST_IN))
		|-> LOOP_LOCK_INDICATOR_OUT != $past(LOOP_LOCK_INDICATOR_OUT))
		else $error("sync clock not at port rate");

	a_non_interleave: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(running && phase_q == PH_SECOND && !interleave) |=> CORE_DATA_OUT == $past(pair_q.port1))
		else $error("second port played in single port mode");
endmodule

// >>> tb/ddc_src_model.sv
/*
 * Behavioural data source that feeds sample pairs into the two input ports.
 * Assumes it shares MCLK_IN with the block and sees the block's ready flag.
 */
`timescale 1ns/1ns

// ==========================================================
// Source model: holds each pair until it is taken
module ddc_src_model
	import ddc_pkg::*;
(
	input  wire logic  clk_in,    // Shared clock
	input  wire logic  rst_in,    // Asynchronous reset, high
	input  wire logic  ready_in,  // Block can take a pair
	input  wire logic  go_in,     // Offer pairs
	input  wire logic  mid_in,    // Hold port 2 at midscale
	input  wire logic  stall_in,  // Leave random gaps
	output logic       valid_out, // Pair valid
	output ddc_pair_t  data_out   // Pair on both ports
);
	// Load a new pair once the old one is taken, else keep it
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			valid_out <= 1'b0;
			data_out  <= '0;
		end else if (!valid_out || ready_in) begin
			valid_out <= go_in && !(stall_in && $urandom_range(1, 0) == 0);
			if (go_in) begin
				data_out.port1 <= SAMPLE_W'($urandom);
				data_out.port2 <= mid_in ? 10'h200 : SAMPLE_W'($urandom);
			end else begin
				data_out <= ~data_out;                 // Idle lines do not keep data
			end
		end
	end
endmodule

// >>> tb/tb_top.sv
/*
 * Self-checking bench for the converter clock mode and interleave control.
 * Assumes ddc_top and ddc_src_model compiled before it; one 250 MHz clock.
 */
`timescale 1ns/1ns

module tb_top
	import ddc_pkg::*;
;
	// ==========================================================
	// Signals
	logic        mclk, rst, cyc, stb, we;   // Clock, reset, bus strobes
	logic [7:0]  adr;                       // Bus address
	logic [3:0]  sel, sel_n;                // Bus byte enables, lanes for next call
	logic [31:0] wdat, rdat, r;             // Bus data
	logic        ack, go, mid, stall;       // Ack and source controls
	logic        valid, ready, upd, ind;    // Stream and core flags
	ddc_pair_t   sdata, cur;                // Source pair, pair playing
	logic [9:0]  core_data;                 // Core sample
	ddc_pair_t   exp_q[$];                  // Pairs noted on acceptance
	logic        slot, ni, loop_on, rep;    // Checker state, mode notes
	int          n_errors, checks_done;     // Counters

	ddc_top i_ddc_top (.MCLK_IN(mclk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .SRC_VALID_IN(valid), .SRC_DATA_IN(sdata), .SRC_READY_OUT(ready),
		.CORE_DATA_OUT(core_data), .CORE_UPDATE_OUT(upd), .LOOP_LOCK_INDICATOR_OUT(ind));
	ddc_src_model i_ddc_src_model (.clk_in(mclk), .rst_in(rst), .ready_in(ready), .go_in(go),
		.mid_in(mid), .stall_in(stall), .valid_out(valid), .data_out(sdata));

	// Full-rate clock from the source side in both modes
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ==========================================================
	// Shared tasks
	task check(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask

	task test_done();
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Classic single cycle; holds until ack is seen at an edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		sel <= sel_n;
		for (i = 0; i < 20; i++) begin
			@(posedge mclk);
			if (ack === 1'b1) break;
		end
		r = rdat;
		cyc <= 1'b0; stb <= 1'b0;
		if (i == 20) begin
			check(1'b0, "bus ack missing");
			test_done();
		end
	endtask

	// Waits for lock, counting from n0, with the core idle meanwhile
	task wait_lock(input int n0);
		int i, u;
		u = 0;
		for (i = n0; i < 400 && ind !== 1'b1; i++) begin
			@(posedge mclk);
			if (i > n0 + 3 && upd === 1'b1 && ind !== 1'b1) u++;
		end
		check(i >= LOCK_CYCLES - 8 && i <= LOCK_CYCLES + 8, "lock time off");
		check(u == 0, "core updated before lock");
		if (ind !== 1'b1) test_done();                                        // Lock never came
	endtask

	// ==========================================================
	// Note accepted pairs and compare each core update, mid-cycle where outputs are settled
	always @(negedge mclk or posedge rst) begin
		if (rst) begin
			exp_q.delete(); cur = '0; slot = 1'b0; rep = 1'b0;
		end else begin
			if (upd === 1'b1 && !slot) begin
				rep = !(exp_q.size() > 0 && core_data === exp_q[0].port1);
				if (!rep) cur = exp_q.pop_front();
				check(core_data === cur.port1, "first sample wrong");
				if (!loop_on) check(ind === 1'b1, "sync clock low in slot 1");
				slot = 1'b1;
			end else if (upd === 1'b1) begin
				check(core_data === (ni ? cur.port1 : cur.port2) ||
					(rep && core_data === cur.port1), "second sample wrong");
				if (!loop_on) check(ind === 1'b0, "sync clock high in slot 2");
				slot = 1'b0;
			end else begin
				slot = 1'b0;                        // Idle core: next update is port 1
			end
			if (valid && ready === 1'b1) exp_q.push_back(sdata);
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h8c7e));
		rst = 1'b1; cyc = 0; stb = 0; we = 0; adr = '0; wdat = '0;
		sel = 4'h0; sel_n = 4'hf;
		go = 0; mid = 0; stall = 0; ni = 0; loop_on = 0;
		n_errors = 0; checks_done = 0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		wb(0, CTRL_OFS, 0);    check(r[2:0] === CTRL_RESET, "ctrl reset value");
		wb(1, 8'h0c, 32'h7);
		wb(0, 8'h0c, 0);       check(r === 32'h0, "unmapped read not zero");
		wb(0, CTRL_OFS, 0);    check(r[2:0] === 3'h0, "unmapped write landed");
		sel_n = 4'he;
		wb(1, CTRL_OFS, 32'h7);
		sel_n = 4'hf;
		wb(0, CTRL_OFS, 0);    check(r[2:0] === 3'h0, "write without low lane landed");
		go <= 1'b1;
		repeat (100) @(posedge mclk);
		wb(1, STATUS_OFS, 32'h4);
		wb(0, STATUS_OFS, 0);  check(r[2] === 1'b0, "underrun not cleared");
		mid <= 1'b1;
		repeat (60) @(posedge mclk);
		go <= 1'b0;
		repeat (40) @(posedge mclk);
		wb(0, STATUS_OFS, 0);  check(r[2] === 1'b1, "underrun not flagged");
		mid <= 1'b0;
		for (int s = 1; s <= 4; s++) begin
			wb(1, CTRL_OFS, 32'((s % 4) << 1));
			ni = (s != 4);
			go <= 1'b1;
			repeat (60) @(posedge mclk);
			go <= 1'b0;
			repeat (30) @(posedge mclk);
		end
		// Multiplier on: fifo fills while the loop settles, source stalls
		loop_on = 1'b1;
		stall <= 1'b1;
		wb(1, CTRL_OFS, 32'h1);
		go <= 1'b1;
		repeat (100) @(posedge mclk);
		check(ready === 1'b0, "fifo not full");
		wb(0, STATUS_OFS, 0);  check(r[7:4] === 4'h8 && r[0] === 1'b0, "fill or lock wrong");
		wait_lock(103);
		repeat (100) @(posedge mclk);
		wb(1, CTRL_OFS, 32'h7);
		wb(0, STATUS_OFS, 0);  check(r[0] === 1'b0, "ratio change kept lock");
		wait_lock(3);
		go <= 1'b0;
		repeat (60) @(posedge mclk);
		// Reset in mid-run, then external mode again
		rst <= 1'b1; loop_on = 1'b0; stall <= 1'b0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		wb(0, CTRL_OFS, 0);    check(r[2:0] === CTRL_RESET, "ctrl after reset");
		go <= 1'b1;
		repeat (50) @(posedge mclk);
		go <= 1'b0;
		repeat (40) @(posedge mclk);
		check(exp_q.size() == 0, "pairs never played");
		test_done();
	end
endmodule
